//--- design/swb_pkg.sv
/*
 * shared constants and types for the store write buffer.
 * assumes a single 100 MHz clock domain and a synchronous active-low reset.
 */
package swb_pkg;
  localparam int SWB_ADDR_W = 32;
  localparam int SWB_DATA_W = 32;
  localparam int SWB_DEPTH = 16;
  localparam int SWB_BE_W = 4;
  // entry: byte enables, address, data
  localparam int SWB_ENTRY_W = SWB_BE_W + SWB_ADDR_W + SWB_DATA_W;
  // write buffer disable bit of the core configuration register
  localparam int SWB_CFG_WB_DIS_BIT = 22;
  localparam logic [SWB_BE_W-1:0] SWB_BE_NONE = 4'h0;

  typedef enum logic [0:0] {
    SWB_BUS_IDLE,
    SWB_BUS_WAIT
  } swb_bus_state_t;

  typedef struct packed {
    logic [SWB_BE_W-1:0] be;
    logic [SWB_ADDR_W-1:0] addr;
    logic [SWB_DATA_W-1:0] data;
  } swb_entry_t;
endpackage : swb_pkg

//--- design/swb_stream_if.sv
/*
 * valid/ready stream carrying one write buffer entry.
 * assumes both ends share the processor clock.
 */
interface swb_stream_if;
  import swb_pkg::*;
  logic valid;
  logic ready;
  swb_entry_t entry;
  modport src (output valid, output entry, input ready);
  modport dst (input valid, input entry, output ready);
endinterface : swb_stream_if

//--- design/swb_fifo.sv
/*
 * first-in-first-out queue of write entries with valid/ready on both sides.
 * assumes one clock; read data come from a register that holds the head entry.
 */
module swb_fifo #(
  parameter int WIDTH = 68,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  // one push and one pop per cycle, each entry written exactly once
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage; pointers wrap on the power-of-two depth
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // registered head; bypass the memory when it is empty or just written
  always_ff @(posedge clock) begin
    if (!nrst) begin
      out_data <= '0;
    end else if (push && (count == '0 || (pop && count == (AW+1)'(1)))) begin
      out_data <= in_data;
    end else if (pop) begin
      out_data <= mem[rd_ptr + 1'b1];
    end
  end
endmodule : swb_fifo

//--- design/swb_bus_port.sv
/*
 * drains queued entries onto the system bus, one write per grant.
 * assumes the bus holds grant high for one cycle when it takes the write.
 */
module swb_bus_port (
  input wire logic clock,
  input wire logic nrst,
  swb_stream_if.dst q,
  output logic bus_req,
  output logic [swb_pkg::SWB_ADDR_W-1:0] bus_addr,
  output logic [swb_pkg::SWB_DATA_W-1:0] bus_wdata,
  output logic [swb_pkg::SWB_BE_W-1:0] bus_be,
  input wire logic bus_grant,
  output logic busy
);
  import swb_pkg::*;

  // request straight from the queue head; grant retires the oldest entry
  assign bus_req = q.valid;
  assign q.ready = bus_grant && q.valid;
  assign busy = q.valid;
  assign bus_addr = q.entry.addr;
  assign bus_wdata = q.entry.data;
  assign bus_be = q.entry.be;
endmodule : swb_bus_port

//--- design/swb_top.sv
/*
 * processor store write buffer: merge latch, 16-entry queue, bus drain.
 * assumes the core holds a store request until store_ready and that the
 * system bus answers each request with a one-cycle grant.
 */
// Behaviour
// - uncached stores and store misses enter buffer
// - sixteen-entry queue, issued in accepted order
// - bus grant retires the oldest entry
// - latch pushes on nonmerge, load hit, flush
// - uncached stores never merge in latch
// - drain barrier empties buffer before later stores
// - barrier forces pending writes out
// - config bit 22 disables the buffer
// - disabled: stall until previous write completes
module swb_top (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [31:0] cpu_config_register_zero,
  input wire logic store_valid,
  output logic store_ready,
  input wire logic store_uncached,
  input wire logic store_miss,
  input wire logic [swb_pkg::SWB_ADDR_W-1:0] store_addr,
  input wire logic [swb_pkg::SWB_DATA_W-1:0] store_data,
  input wire logic [swb_pkg::SWB_BE_W-1:0] store_be,
  input wire logic load_valid,
  input wire logic [swb_pkg::SWB_ADDR_W-1:0] load_addr,
  output logic load_hit_latch,
  input wire logic sync_req,
  output logic sync_done,
  output logic bus_req,
  output logic [swb_pkg::SWB_ADDR_W-1:0] bus_addr,
  output logic [swb_pkg::SWB_DATA_W-1:0] bus_wdata,
  output logic [swb_pkg::SWB_BE_W-1:0] bus_be,
  input wire logic bus_grant,
  output logic buffer_empty
);
  import swb_pkg::*;

  swb_stream_if fin ();
  swb_stream_if fout ();

  logic latch_valid;
  logic latch_nomerge;
  swb_entry_t latch;
  logic q_busy;
  logic wb_disabled;
  logic take_store;
  logic mergeable_hit;
  logic flush_push;
  logic push_latch;
  logic latch_free;
  logic sync_pending;
  swb_entry_t next_latch;

  // word-address match, shared by merge and load-hit checks
  function automatic logic swb_same_word(input logic [SWB_ADDR_W-1:0] a,
                                         input logic [SWB_ADDR_W-1:0] b);
    swb_same_word = (a[SWB_ADDR_W-1:2] == b[SWB_ADDR_W-1:2]);
  endfunction : swb_same_word

  // byte-lane merge of a new store into the held word
  function automatic swb_entry_t swb_merge(input swb_entry_t old_e,
                                           input logic [SWB_DATA_W-1:0] d,
                                           input logic [SWB_BE_W-1:0] be);
    swb_entry_t r;
    r = old_e;
    for (int i = 0; i < SWB_BE_W; i++) begin
      if (be[i]) begin
        r.data[8*i +: 8] = d[8*i +: 8];
      end
    end
    r.be = old_e.be | be;
    swb_merge = r;
  endfunction : swb_merge

  assign wb_disabled = cpu_config_register_zero[SWB_CFG_WB_DIS_BIT];
  assign buffer_empty = !latch_valid && !q_busy;

  // load hitting the held word forces it out so the load sees memory order
  assign load_hit_latch = latch_valid && load_valid && swb_same_word(load_addr, latch.addr);

  // a store may merge only if both it and the latch are cacheable misses;
  // never while a load hit is pushing the latch, or the old word goes out twice
  assign mergeable_hit = latch_valid && !latch_nomerge && !store_uncached
                         && !load_hit_latch
                         && swb_same_word(store_addr, latch.addr);

  // barrier, load hit, nonmergeable follower or disabled mode push the latch
  assign flush_push = sync_pending || load_hit_latch || wb_disabled;
  assign push_latch = latch_valid && (flush_push || latch_nomerge
                      || (store_valid && !mergeable_hit));

  // the queue takes the latch only when it has room; single push path so the
  // entry lands in one slot; a full queue refuses it even while a grant pops
  assign fin.valid = push_latch;
  assign fin.entry = latch;
  assign latch_free = !latch_valid || (push_latch && fin.ready);

  // stores wait out a barrier; disabled mode waits for an idle bus
  always_comb begin
    store_ready = 1'b0;
    if (store_valid && (store_uncached || store_miss) && !sync_pending) begin
      if (wb_disabled) begin
        store_ready = latch_free && !q_busy && !latch_valid;
      end else begin
        store_ready = mergeable_hit || latch_free;
      end
    end
  end
  assign take_store = store_valid && store_ready;

  always_comb begin
    next_latch.be = store_be;
    next_latch.addr = store_addr;
    next_latch.data = store_data;
    if (mergeable_hit) begin
      next_latch = swb_merge(latch, store_data, store_be);
    end
  end

  // merge latch
  always_ff @(posedge clock) begin
    if (!nrst) begin
      latch_valid <= 1'b0;
      latch_nomerge <= 1'b0;
      latch <= '0;
    end else if (take_store) begin
      latch_valid <= 1'b1;
      latch_nomerge <= store_uncached;
      latch <= next_latch;
    end else if (push_latch && fin.ready) begin
      latch_valid <= 1'b0;
      latch_nomerge <= 1'b0;
    end
  end

  // barrier stays pending until latch and queue are both drained
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sync_pending <= 1'b0;
    end else if (sync_req) begin
      sync_pending <= 1'b1;
    end else if (buffer_empty) begin
      sync_pending <= 1'b0;
    end
  end
  assign sync_done = sync_pending && buffer_empty && !sync_req;

  swb_fifo #(
    .WIDTH(SWB_ENTRY_W),
    .DEPTH(SWB_DEPTH)
  ) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_valid(fin.valid),
    .in_ready(fin.ready),
    .in_data(fin.entry),
    .out_valid(fout.valid),
    .out_ready(fout.ready),
    .out_data(fout.entry),
    .count()
  );

  swb_bus_port u_bus (
    .clock(clock),
    .nrst(nrst),
    .q(fout),
    .bus_req(bus_req),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_be(bus_be),
    .bus_grant(bus_grant),
    .busy(q_busy)
  );
endmodule : swb_top

//--- bench/swb_chk.sv
/* port checker for the store write buffer top.
   assumes one clock and nrst low for reset; bound into swb_top. */
module swb_chk (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [31:0] cpu_config_register_zero,
  input wire logic store_valid,
  input wire logic store_ready,
  input wire logic store_uncached,
  input wire logic store_miss,
  input wire logic load_hit_latch,
  input wire logic sync_done,
  input wire logic bus_req,
  input wire logic [swb_pkg::SWB_ADDR_W-1:0] bus_addr,
  input wire logic [swb_pkg::SWB_DATA_W-1:0] bus_wdata,
  input wire logic [swb_pkg::SWB_BE_W-1:0] bus_be,
  input wire logic bus_grant,
  input wire logic buffer_empty
);
  timeunit 1ns;
  timeprecision 100ps;
  import swb_pkg::*;
  logic dis;
  // disable bit as a level
  assign dis = cpu_config_register_zero[SWB_CFG_WB_DIS_BIT];
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  hold_req_a: assert property (
    bus_req && !bus_grant |=> bus_req && $stable({bus_be, bus_addr, bus_wdata}))
    else $error("bus write dropped or changed before grant");
  empty_idle_a: assert property (buffer_empty && !store_valid |=> buffer_empty)
    else $error("write appeared without a store");
  sync_empty_a: assert property (sync_done |-> buffer_empty)
    else $error("barrier done with writes still buffered");
  flag_refuse_a: assert property (
    store_valid && !store_uncached && !store_miss |-> !store_ready)
    else $error("cache hit store taken by buffer");
  dis_stall_a: assert property (dis && !buffer_empty |-> !store_ready)
    else $error("disabled buffer took a store while busy");
  dis_push_a: assert property (dis && store_valid && store_ready |-> ##[1:3] bus_req)
    else $error("disabled buffer held a store");
  nomerge_push_a: assert property (
    store_valid && store_ready && store_uncached && buffer_empty |-> ##2 bus_req)
    else $error("uncached store not pushed at once");
  hit_push_a: assert property (load_hit_latch |-> ##[1:3] bus_req)
    else $error("load hit did not push the latch");
  cover property (store_valid && !store_ready && !dis);
  cover property (sync_done);
  cover property (load_hit_latch);
  // store accepted while the bus retires an entry, with the buffer enabled
  cover property (bus_grant && store_valid && store_ready && !dis);
endmodule : swb_chk

bind swb_top swb_chk u_chk (.clock, .nrst, .cpu_config_register_zero, .store_valid, .store_ready,
  .store_uncached, .store_miss, .load_hit_latch, .sync_done, .bus_req, .bus_addr, .bus_wdata,
  .bus_be, .bus_grant, .buffer_empty);

//--- bench/swb_bus_model.sv
/* system bus model: grants one pending write per one-cycle pulse.
   assumes the bench drives stall to make it slow. */
module swb_bus_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic bus_req,
  input wire logic stall,
  output logic bus_grant
);
  timeunit 1ns;
  timeprecision 100ps;
  initial bus_grant = 1'b0;
  // random grants, back to back allowed so pop and push can coincide
  always @(posedge clock) begin
    #1 bus_grant = nrst && bus_req && !stall;
  end
endmodule : swb_bus_model

//--- bench/test_store_write_buffer.sv
/* self-checking bench for the store write buffer.
   assumes the bus model beside uut and the checker bound in. */
module test_store_write_buffer;
  timeunit 1ns;
  timeprecision 100ps;
  import swb_pkg::*;
  logic clock = 0, nrst = 0, store_valid = 0, store_uncached = 0, store_miss = 0;
  logic load_valid = 0, sync_req = 0, stall = 1, hold = 1;
  logic store_ready, load_hit_latch, sync_done, bus_req, bus_grant, buffer_empty;
  logic [31:0] cpu_config_register_zero = 0;
  logic [SWB_ADDR_W-1:0] store_addr = 0, load_addr = 0, bus_addr;
  logic [SWB_DATA_W-1:0] store_data = 0, bus_wdata;
  logic [SWB_BE_W-1:0] store_be = 0, bus_be;
  logic [15:0] lf = 16'h211C;
  int fails = 0, checked = 0;
  swb_entry_t exp_q[$];
  swb_entry_t e1, e2;
  swb_top uut (.clock, .nrst, .cpu_config_register_zero, .store_valid, .store_ready,
    .store_uncached, .store_miss, .store_addr, .store_data, .store_be, .load_valid, .load_addr,
    .load_hit_latch, .sync_req, .sync_done, .bus_req, .bus_addr, .bus_wdata, .bus_be,
    .bus_grant, .buffer_empty);
  swb_bus_model bus (.clock, .nrst, .bus_req, .stall, .bus_grant);
  always #5 clock = ~clock;
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // random stalls once the hold is lifted; updated on the edge so the
  // bus model, which samples one step later, never races it
  always @(posedge clock) begin
    lf <= lfsr_next(lf);
    stall <= hold | lf[0];
  end
  function automatic swb_entry_t ent(input logic [3:0] be);
    return '{be, {16'h1000, lf[13:0], 2'h0}, {lf, ~lf}};
  endfunction : ent
  task automatic chk(input string what, input logic [SWB_ENTRY_W-1:0] e,
                     input logic [SWB_ENTRY_W-1:0] g);
    checked++;
    if (e !== g) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // valid stays up afterwards so back-to-back stores keep one driver step
  task automatic put(input swb_entry_t e, input logic unc, input logic note);
    int n;
    n = 0;
    store_valid = 1;
    store_uncached = unc;
    store_miss = !unc;
    {store_be, store_addr, store_data} = e;
    #1;
    while (store_ready !== 1'b1 && n < 300) begin
      @(posedge clock);
      #2;
      n++;
    end
    if (n == 300) fails++;
    if (note) exp_q.push_back(e);
    @(posedge clock);
    #1;
  endtask : put
  // barrier pulse, bounded wait; done only shows once the request is low
  task automatic drain();
    int n;
    n = 0;
    store_valid = 0;
    sync_req = 1;
    @(posedge clock);
    #1 sync_req = 0;
    while (sync_done !== 1'b1 && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("drained", SWB_ENTRY_W'(3),
        SWB_ENTRY_W'({buffer_empty, exp_q.size() == 0}));
    @(posedge clock);
    #1;
  endtask : drain
  task automatic test_done();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  // every granted write must be the oldest noted store, exactly once
  always @(posedge clock) begin
    if (nrst && bus_req === 1'b1 && bus_grant === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("mismatch bus write expected none seen %h", bus_addr);
      end else chk("bus write", exp_q.pop_front(), {bus_be, bus_addr, bus_wdata});
    end
  end
  // hang guard, far above the few hundred cycles the run needs
  initial begin
    #200000;
    fails++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge clock);
    #1 nrst = 1;
    repeat (17) put(ent(4'hF), 1, 1);
    fork
      put(ent(4'hF), 1, 1);
      begin
        repeat (3) @(posedge clock);
        #2 chk("full refuse", '0, SWB_ENTRY_W'(store_ready));
        @(posedge clock);
        #1 hold = 0;
      end
    join
    repeat (24) put(ent(4'hF), 1, 1);
    drain();
    e1 = ent(4'h3);
    e2 = e1;
    e2.be = 4'hC;
    e2.data = ~e1.data;
    put(e1, 0, 0);
    put(e2, 0, 0);
    store_valid = 0;
    load_addr = e1.addr;
    load_valid = 1;
    #1 chk("load hit", SWB_ENTRY_W'(1), SWB_ENTRY_W'(load_hit_latch));
    exp_q.push_back('{4'hF, e1.addr, {e2.data[31:16], e1.data[15:0]}});
    @(posedge clock);
    #1 load_valid = 0;
    drain();
    cpu_config_register_zero[SWB_CFG_WB_DIS_BIT] = 1;
    put(ent(4'hF), 1, 1);
    fork
      put(ent(4'hF), 0, 1);
      #1 chk("disabled stall", '0, SWB_ENTRY_W'(store_ready));
    join
    drain();
    cpu_config_register_zero[SWB_CFG_WB_DIS_BIT] = 0;
    test_done();
  end
endmodule : test_store_write_buffer
